/* pkg/pbcs_cfg.svh */
// constants for the basic transceiver control and status register pair
`ifndef PBCS_CFG_SVH
`define PBCS_CFG_SVH
`define PBCS_IDX_CONTROL 8'h00
`define PBCS_IDX_STATUS 8'h01
`define PBCS_ADDR_CONTROL 8'h00
`define PBCS_ADDR_STATUS 8'h04
`define PBCS_ADDR_EVT 8'h08
`define PBCS_ADDR_MASK 8'h0c
`define PBCS_B_RESET 15
`define PBCS_B_LOOPBACK 14
`define PBCS_B_SPEED_LSB 13
`define PBCS_B_AN_EN 12
`define PBCS_B_PWRDN 11
`define PBCS_B_ISOLATE 10
`define PBCS_B_AN_RESTART 9
`define PBCS_B_DUPLEX 8
`define PBCS_B_COLTEST 7
`define PBCS_B_SPEED_MSB 6
`define PBCS_S_AN_DONE 5
`define PBCS_S_RFAULT 4
`define PBCS_S_LINK 2
`define PBCS_S_JABBER 1
`define PBCS_STATUS_FIXED 16'h7809
`define PBCS_SRST_NS 1000
`define PBCS_SRST_CYC ((`PBCS_SRST_NS + 7) / 8)
`define PBCS_EVT_W 4
`endif

/* pkg/pbcs_pkg.sv */
// types for the basic transceiver control and status register pair
package pbcs_pkg;
    typedef enum logic [1:0] {
        PBCS_SPD_10 = 2'h0,
        PBCS_SPD_100 = 2'h1,
        PBCS_SPD_1000 = 2'h2,
        PBCS_SPD_RSVD = 2'h3
    } pbcs_speed_e;
    typedef enum logic [1:0] {
        PBCS_RUN = 2'h0,
        PBCS_SRST = 2'h1
    } pbcs_state_e;
    typedef struct packed {
        logic loopback;
        logic power_down;
        logic isolate;
        logic full_duplex;
        logic col_test;
        logic an_enable;
        pbcs_speed_e speed;
    } pbcs_mode_s;
    typedef struct packed {
        logic link_up;
        logic an_complete;
        logic remote_fault;
        logic jabber;
    } pbcs_line_s;
endpackage

/* design/pbcs_regs.sv */
// basic control and status register pair of a 10/100 transceiver, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "pbcs_cfg.svh"
module pbcs_regs #(
    parameter int SRST_CYCLES = `PBCS_SRST_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] indicator_strap_pins,
    input wire pbcs_pkg::pbcs_line_s line_state,
    output pbcs_pkg::pbcs_mode_s mode,
    output logic an_restart,
    output logic core_reset,
    output logic irq
);
    logic [15:0] ctrl_ff;
    logic [2:0] strap_ff;
    logic strap_taken_ff;
    pbcs_pkg::pbcs_state_e state_ff;
    logic [31:0] srst_cnt_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic link_ll_ff, rfault_lh_ff, jabber_lh_ff;
    logic [`PBCS_EVT_W-1:0] evt_ff, mask_ff;
    pbcs_pkg::pbcs_line_s line_q_ff;
    logic do_wr, do_rd, ctrl_wr, stat_rd, evt_rd, soft_rst;
    logic [15:0] nxt_ctrl, status_word;
    logic [`PBCS_EVT_W-1:0] evt_new;

    assign do_wr = aw_ff && w_ff && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && s_axi_arready;
    assign ctrl_wr = do_wr && awaddr_ff == `PBCS_ADDR_CONTROL && (&wstrb_ff[1:0]);
    assign stat_rd = do_rd && s_axi_araddr == `PBCS_ADDR_STATUS;
    assign evt_rd = do_rd && s_axi_araddr == `PBCS_ADDR_EVT;
    assign soft_rst = state_ff == pbcs_pkg::PBCS_SRST;

    // strap levels caught on the first clocked cycle after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken_ff <= 1'b0;
            strap_ff <= 3'h0;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            strap_ff <= indicator_strap_pins;
        end
    end

    // write channel: address and data taken in either order, held until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_ff;
    assign s_axi_wready = !w_ff;
    assign s_axi_bresp = 2'h0;

    // control register next value; reserved bits 5:0 forced to zero
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ctrl[`PBCS_B_AN_RESTART] = 1'b0;
        // outside the timed reset the reset bit must read 0 again
        nxt_ctrl[`PBCS_B_RESET] = 1'b0;
        if (ctrl_wr) begin
            nxt_ctrl = {wdata_ff[15:6], 6'h00};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= 16'h0000;
        end else if (!strap_taken_ff || soft_rst) begin
            // defaults: strap bits for an enable, speed and duplex, reset bit set during the soft reset, others zero
            ctrl_ff <= 16'h0000;
            ctrl_ff[`PBCS_B_RESET] <= soft_rst;
            ctrl_ff[`PBCS_B_AN_EN] <= strap_taken_ff ? strap_ff[2] : indicator_strap_pins[2];
            ctrl_ff[`PBCS_B_SPEED_LSB] <= strap_taken_ff ? strap_ff[1] : indicator_strap_pins[1];
            ctrl_ff[`PBCS_B_DUPLEX] <= strap_taken_ff ? strap_ff[0] : indicator_strap_pins[0];
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // soft reset sequencer: the reset bit reads 1 until the timed reset ends
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= pbcs_pkg::PBCS_RUN;
            srst_cnt_ff <= 32'h0;
        end else unique case (state_ff)
            pbcs_pkg::PBCS_RUN: begin
                if (ctrl_wr && wdata_ff[`PBCS_B_RESET]) begin
                    state_ff <= pbcs_pkg::PBCS_SRST;
                    srst_cnt_ff <= 32'h0;
                end
            end
            pbcs_pkg::PBCS_SRST: begin
                srst_cnt_ff <= srst_cnt_ff + 32'h1;
                if (srst_cnt_ff >= 32'(SRST_CYCLES - 1)) begin
                    state_ff <= pbcs_pkg::PBCS_RUN;
                end
            end
            default: state_ff <= pbcs_pkg::PBCS_RUN;
        endcase
    end

    // line status latches; a new event wins over the clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            line_q_ff <= '0;
            link_ll_ff <= 1'b0;
            rfault_lh_ff <= 1'b0;
            jabber_lh_ff <= 1'b0;
        end else begin
            line_q_ff <= line_state;
            link_ll_ff <= stat_rd ? line_state.link_up : (link_ll_ff & line_state.link_up);
            rfault_lh_ff <= (rfault_lh_ff & !stat_rd) | line_state.remote_fault;
            jabber_lh_ff <= (jabber_lh_ff & !stat_rd) | line_state.jabber;
        end
    end

    always_comb begin
        status_word = `PBCS_STATUS_FIXED;
        status_word[`PBCS_S_AN_DONE] = line_state.an_complete;
        status_word[`PBCS_S_RFAULT] = rfault_lh_ff | line_state.remote_fault;
        status_word[`PBCS_S_LINK] = link_ll_ff & line_state.link_up;
        status_word[`PBCS_S_JABBER] = jabber_lh_ff | line_state.jabber;
    end

    // events: link change, an complete rise, remote fault rise, jabber rise
    assign evt_new = {line_state.link_up ^ line_q_ff.link_up,
                      line_state.an_complete & !line_q_ff.an_complete,
                      line_state.remote_fault & !line_q_ff.remote_fault,
                      line_state.jabber & !line_q_ff.jabber};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_ff <= '0;
            mask_ff <= '0;
        end else begin
            evt_ff <= (evt_rd ? '0 : evt_ff) | evt_new;
            if (do_wr && awaddr_ff == `PBCS_ADDR_MASK && wstrb_ff[0]) begin
                mask_ff <= wdata_ff[`PBCS_EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((evt_rd ? '0 : evt_ff) | evt_new) & mask_ff);
        end
    end

    // read channel: one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
                `PBCS_ADDR_CONTROL: s_axi_rdata <= {16'h0, ctrl_ff};
                `PBCS_ADDR_STATUS: s_axi_rdata <= {16'h0, status_word};
                `PBCS_ADDR_EVT: s_axi_rdata <= {28'h0, evt_ff};
                `PBCS_ADDR_MASK: s_axi_rdata <= {28'h0, mask_ff};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

    // mode outputs registered; speed decode per the two selection bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= '0;
            an_restart <= 1'b0;
            core_reset <= 1'b1;
        end else begin
            mode.loopback <= ctrl_ff[`PBCS_B_LOOPBACK];
            mode.power_down <= ctrl_ff[`PBCS_B_PWRDN];
            mode.isolate <= ctrl_ff[`PBCS_B_ISOLATE];
            mode.full_duplex <= ctrl_ff[`PBCS_B_DUPLEX];
            mode.col_test <= ctrl_ff[`PBCS_B_COLTEST];
            mode.an_enable <= ctrl_ff[`PBCS_B_AN_EN];
            mode.speed <= pbcs_pkg::pbcs_speed_e'({ctrl_ff[`PBCS_B_SPEED_MSB],
                                                  ctrl_ff[`PBCS_B_SPEED_LSB]});
            an_restart <= ctrl_wr && wdata_ff[`PBCS_B_AN_RESTART];
            core_reset <= soft_rst || !strap_taken_ff;
        end
    end
endmodule // pbcs_regs
`default_nettype wire

/* tb/pbcs_line_model.sv */
// behavioural model of the line conditions reported by the transceiver core
`timescale 1ns/1ps
`default_nettype none
module pbcs_line_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] cond,
    output pbcs_pkg::pbcs_line_s line_state
);
    // registered, so a one-cycle pulse on cond reaches the block as one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) line_state <= '0;
        else line_state <= cond;
    end
endmodule // pbcs_line_model
`default_nettype wire

/* tb/pbcs_regs_props.sv */
// concurrent checks on the ports of the register pair
`timescale 1ns/1ps
`default_nettype none
module pbcs_regs_props #(parameter int SRST_CYCLES = 125) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pbcs_pkg::pbcs_mode_s mode,
    input wire logic an_restart,
    input wire logic core_reset
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_ctl; s_wr ##0 (s_axi_awaddr == 8'h00 && !s_axi_wdata[15]); endsequence
    a_read_answer: assert property (s_rd |=> s_axi_rvalid)
        else $error("read not answered");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_write_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_status_fixed: assert property (s_rd ##0 s_axi_araddr == 8'h04 |=> (s_axi_rdata[15:0] & 16'hffc9) == 16'h7809)
        else $error("fixed status bits wrong");
    a_unmapped_err: assert property (s_rd ##0 s_axi_araddr > 8'h0c |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_speed_follow: assert property (s_ctl |-> ##3 mode.speed == {$past(s_axi_wdata[6], 3), $past(s_axi_wdata[13], 3)})
        else $error("speed not taken from control");
    a_mode_bits: assert property (s_ctl |-> ##3 mode.loopback == $past(s_axi_wdata[14], 3) && mode.isolate == $past(s_axi_wdata[10], 3))
        else $error("mode bits not taken from control");
    a_restart_pulse: assert property (s_ctl ##0 s_axi_wdata[9] |-> ##[1:2] an_restart ##1 !an_restart)
        else $error("restart not a single pulse");
    a_soft_reset: assert property (s_wr ##0 (s_axi_awaddr == 8'h00 && s_axi_wdata[15]) |-> ##[1:3] core_reset)
        else $error("soft reset not started");
endmodule // pbcs_regs_props
bind pbcs_regs pbcs_regs_props #(.SRST_CYCLES(SRST_CYCLES)) pbcs_regs_props_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mode, .an_restart, .core_reset);
`default_nettype wire

/* tb/pbcs_regs_tb_top.sv */
// self-checking bench for the basic control and status register pair
`timescale 1ns/1ps
`default_nettype none
module pbcs_regs_tb_top;
    localparam int SRST = 16;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wr_rdy, bv, arr, rv, an_restart, core_reset, irq;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, got;
    logic [1:0] br, rr, resp;
    logic [3:0] cond = 0;
    pbcs_pkg::pbcs_line_s line;
    pbcs_pkg::pbcs_mode_s mode;
    int n_fail = 0, n_tests = 0, cyc = 0, n_rs = 0;
    always #4 aclk = ~aclk;
    pbcs_regs #(.SRST_CYCLES(SRST)) pbcs_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .indicator_strap_pins(3'h5), .line_state(line), .mode(mode),
        .an_restart(an_restart), .core_reset(core_reset), .irq(irq));
    pbcs_line_model pbcs_line_model_inst (.aclk(aclk), .aresetn(aresetn), .cond(cond),
        .line_state(line));
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (an_restart === 1'b1) n_rs <= n_rs + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // handshakes judged at the negedge, where inputs already equal the next edge's
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        done = 0;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        while (!done) begin
            @(negedge aclk);
            ta = awv && awr;
            tw = wv && wr_rdy;
            done = bv;
            @(posedge aclk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        bre <= 0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, seen;
        seen = 0;
        ara <= a;
        arv <= 1;
        while (!seen) begin
            @(negedge aclk);
            ta = arv && arr;
            seen = rv;
            @(posedge aclk);
            if (ta) arv <= 0;
        end
        // ready one cycle late, so the answer has to stand
        rre <= 1;
        @(negedge aclk);
        d = rdat;
        r = rr;
        @(posedge aclk);
        rre <= 0;
        @(posedge aclk);
    endtask
    task automatic st(input logic [3:0] c, input logic [31:0] e);
        cond <= c;
        repeat (3) @(posedge aclk);
        rd(8'h04, got, resp);
        chk("status", e, got);
    endtask
    task automatic t_status();
        rd(8'h00, got, resp);
        chk("control", 32'h1100, got);
        st(4'h0, 32'h7809);
        st(4'h8, 32'h7809);
        st(4'h8, 32'h780d);
        st(4'h0, 32'h7809);
        st(4'h8, 32'h7809);
        st(4'h8, 32'h780d);
        st(4'hb, 32'h781f);
        st(4'h8, 32'h781f);
        st(4'h8, 32'h780d);
        st(4'hc, 32'h782d);
        st(4'h8, 32'h780d);
        $display("status test done");
    endtask
    task automatic t_control();
        int bt[6] = '{14, 11, 10, 8, 7, 12};
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, (32'(k / 2) << 6) | (32'(k % 2) << 13));
            chk("speed", 32'(k), 32'(mode.speed));
            rd(8'h00, got, resp);
            chk("control", (32'(k / 2) << 6) | (32'(k % 2) << 13), got);
        end
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, 32'h1 << bt[i]);
            chk("mode", 32'h80 >> i, 32'(mode));
        end
        wr(8'h00, 32'h1200);
        repeat (3) @(posedge aclk);
        chk("restarts", 32'h1, 32'(n_rs));
        rd(8'h00, got, resp);
        chk("control", 32'h1000, got);
        $display("control test done");
    endtask
    task automatic t_soft_reset();
        wr(8'h00, 32'h8000);
        chk("core_reset", 32'h1, 32'(core_reset));
        rd(8'h00, got, resp);
        chk("reset bit", 32'h1, 32'(got[15]));
        repeat (SRST + 4) @(posedge aclk);
        rd(8'h00, got, resp);
        chk("control", 32'h1100, got);
        $display("soft reset test done");
    endtask
    task automatic t_irq();
        wr(8'h0c, 32'h1);
        rd(8'h08, got, resp);
        cond <= 4'h9;
        @(posedge aclk);
        cond <= 4'h8;
        repeat (3) @(posedge aclk);
        chk("irq", 32'h1, 32'(irq));
        rd(8'h08, got, resp);
        chk("event", 32'h1, got & 32'h1);
        chk("irq", 32'h0, 32'(irq));
        wr(8'h0c, 32'h0);
        cond <= 4'h9;
        @(posedge aclk);
        cond <= 4'h8;
        repeat (3) @(posedge aclk);
        chk("irq", 32'h0, 32'(irq));
        rd(8'h10, got, resp);
        chk("rresp", 32'h2, 32'(resp));
        $display("irq test done");
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_status();
        t_control();
        t_soft_reset();
        t_irq();
        results();
    end
endmodule // pbcs_regs_tb_top
`default_nettype wire
